// ### verilog/psg_top.sv
// Parallel strobe generator with APB register access
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module psg_top #(
  parameter int DATA_WIDTH = 16,
  parameter int LINES = 8
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic tx_word_valid_in,
  input wire logic [DATA_WIDTH-1:0] tx_word_in,
  output logic tx_word_taken_out,
  input wire logic rx_buffers_full_in,
  output logic rx_word_valid_out,
  output logic [DATA_WIDTH-1:0] rx_word_out,
  input wire logic [DATA_WIDTH-1:0] data_pins_in,
  output logic [DATA_WIDTH-1:0] data_pins_out,
  output logic data_pins_oe_out,
  output logic [LINES-1:0] strobe_pins_out,
  output logic [LINES-1:0] strobe_pins_oe_out,
  output logic last_word_flag_out
);
  import psg_pkg::*;

  // ********************************
  // Registers and APB slave
  // ********************************
  logic [15:0] timing_reg, timing_next;
  logic [15:0] output_reg, output_next;
  logic [15:0] count_reg, count_next;
  logic [15:0] remain_reg, remain_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic start_pulse;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic [2:0] presc;
  logic [2:0] edge_pos;
  logic is_rx;

  assign wr_acc = psel_in && penable_in && pwrite_in;
  // Read data is loaded in the setup cycle so it stands at the pready edge
  assign rd_acc = psel_in && !penable_in && !pwrite_in;
  assign presc = timing_reg[PSG_PRESC_LSB +: 3];
  assign edge_pos = timing_reg[PSG_EDGE_LSB +: 3];
  assign is_rx = timing_reg[PSG_DIR_BIT];

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == PSG_TIMING_OFFSET) || (a == PSG_OUTPUT_OFFSET) ||
      (a == PSG_STATUS_OFFSET) || (a == PSG_COUNT_OFFSET);
  endfunction

  assign hit = addr_known(paddr_in);
  // R19 start launches transfer
  assign start_pulse = wr_acc && (paddr_in == PSG_TIMING_OFFSET) && pwdata_in[PSG_START_BIT];

  psg_state_type state_reg, state_next;
  logic last_reg, last_next;

  always_comb begin
    timing_next = timing_reg;
    output_next = output_reg;
    count_next = count_reg;
    prdata_next = prdata_reg;
    // Error is decided in the setup cycle so it stands through the access phase
    pslverr_next = psel_in && !hit;
    if (wr_acc) begin
      if (paddr_in == PSG_TIMING_OFFSET) begin
        timing_next = pwdata_in[15:0];
        timing_next[PSG_START_BIT] = 1'b0;
        timing_next[PSG_STOP_BIT] = 1'b0;
      end
      // R1 per-line enables
      if (paddr_in == PSG_OUTPUT_OFFSET) begin
        output_next = pwdata_in[15:0];
      end
      if (paddr_in == PSG_COUNT_OFFSET) begin
        count_next = pwdata_in[15:0];
      end
    end
    if (rd_acc) begin
      case (paddr_in)
        PSG_TIMING_OFFSET: prdata_next = {16'h0000, timing_reg};
        PSG_OUTPUT_OFFSET: prdata_next = {16'h0000, output_reg};
        PSG_STATUS_OFFSET: prdata_next = {16'h0000, remain_reg[12:0], last_reg, state_reg};
        PSG_COUNT_OFFSET: prdata_next = {16'h0000, count_reg};
        default: prdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      timing_reg <= PSG_TIMING_RESET;
      output_reg <= PSG_OUTPUT_RESET;
      count_reg <= 16'h0000;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      timing_reg <= timing_next;
      output_reg <= output_next;
      count_reg <= count_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end
  assign prdata_out = prdata_reg;
  assign pslverr_out = pslverr_reg;
  assign pready_out = 1'b1;

  // ********************************
  // Base tick from system clock
  // ********************************
  // Limitation: the system clock is slower than the 60 MHz base, so one base
  // period is rendered as one system cycle; timing scales by the clock ratio.
  logic base_tick;
  assign base_tick = 1'b1;

  // ********************************
  // Cycle timer
  // ********************************
  logic [2:0] phase;
  logic cycle_end;
  logic hold;
  psg_cycle_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .tick_in(base_tick),
    .restart_in(start_pulse || state_reg == PSG_IDLE),
    .hold_in(hold),
    .presc_in(presc),
    .edge_in(edge_pos),
    .phase_out(phase),
    .cycle_end_out(cycle_end)
  );

  // ********************************
  // Transfer sequencer
  // ********************************
  logic [DATA_WIDTH-1:0] dout_reg, dout_next;
  logic dout_oe_reg, dout_oe_next;
  logic strobe_reg, strobe_next;
  logic taken_reg, taken_next;
  logic rxv_reg, rxv_next;
  logic [DATA_WIDTH-1:0] rxw_reg, rxw_next;
  logic level_start;
  logic stall_tx;
  logic stall_rx;
  logic at_edge;

  // R11 polarity start level
  assign level_start = !timing_reg[PSG_POL_BIT];
  // R9 edge position, R10 no edge when out of range
  // Pins are registered, so the toggle is decided one period ahead of the edge
  assign at_edge = (edge_pos != 3'h0) && (edge_pos <= presc) && (phase == edge_pos - 3'h1);
  assign stall_tx = !is_rx && !tx_word_valid_in;
  assign stall_rx = is_rx && rx_buffers_full_in;
  assign hold = (state_reg == PSG_STALL) || (state_reg == PSG_RUN && is_rx && stall_rx
    && !timing_reg[PSG_OVR_BIT] && (phase >= presc));

  always_comb begin
    state_next = state_reg;
    remain_next = remain_reg;
    last_next = last_reg;
    dout_next = dout_reg;
    dout_oe_next = dout_oe_reg;
    strobe_next = strobe_reg;
    taken_next = 1'b0;
    rxv_next = 1'b0;
    rxw_next = rxw_reg;
    case (state_reg)
      PSG_IDLE: begin
        // R6 idle level when not running
        strobe_next = output_reg[PSG_IDLE_BIT];
        dout_oe_next = 1'b0;
        if (start_pulse && count_next != 16'h0000) begin
          remain_next = count_next;
          // R13 wait for a filled buffer
          state_next = PSG_STALL;
        end
      end
      PSG_STALL: begin
        if (!is_rx && tx_word_valid_in) begin
          // R12 word at cycle start
          state_next = PSG_RUN;
          dout_next = tx_word_in;
          dout_oe_next = 1'b1;
          taken_next = 1'b1;
          strobe_next = level_start;
        end else if (is_rx && !rx_buffers_full_in) begin
          state_next = PSG_RUN;
          strobe_next = level_start;
        end else if (!is_rx || timing_reg[PSG_OVR_BIT]) begin
          // R14 underrun release, R15 overrun release
          strobe_next = output_reg[PSG_IDLE_BIT];
          dout_oe_next = 1'b0;
        end
      end
      PSG_RUN: begin
        // R5 one pulse per word, R2 single generator
        if (at_edge) begin
          strobe_next = !level_start;
          // R20 sample on edge
          if (is_rx && timing_reg[PSG_SAMPLE_EDGE_BIT]) begin
            rxw_next = data_pins_in;
          end
        end
        if (cycle_end) begin
          if (is_rx) begin
            if (!timing_reg[PSG_SAMPLE_EDGE_BIT]) begin
              rxw_next = data_pins_in;
            end
            rxv_next = 1'b1;
          end
          remain_next = remain_reg - 16'h0001;
          if (remain_reg == 16'h0001) begin
            state_next = PSG_IDLE;
            last_next = 1'b1;
            strobe_next = output_reg[PSG_IDLE_BIT];
            dout_oe_next = 1'b0;
          end else if (stall_tx || (stall_rx && timing_reg[PSG_OVR_BIT])) begin
            state_next = PSG_STALL;
            strobe_next = output_reg[PSG_IDLE_BIT];
            dout_oe_next = 1'b0;
          end else if (!is_rx) begin
            dout_next = tx_word_in;
            taken_next = 1'b1;
            strobe_next = level_start;
          end else begin
            strobe_next = level_start;
          end
        end else if (hold) begin
          // R16 hold level through full buffers; sample at stretch end
          rxw_next = rxw_reg;
        end
      end
      default: state_next = PSG_IDLE;
    endcase
    if (timing_reg[PSG_STOP_BIT]) begin
      state_next = PSG_IDLE;
    end
    // R19 clears last-word flag
    if (start_pulse) begin
      last_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= PSG_IDLE;
      remain_reg <= 16'h0000;
      last_reg <= 1'b0;
      dout_reg <= '0;
      dout_oe_reg <= 1'b0;
      strobe_reg <= 1'b0;
      taken_reg <= 1'b0;
      rxv_reg <= 1'b0;
      rxw_reg <= '0;
    end else begin
      state_reg <= state_next;
      remain_reg <= remain_next;
      last_reg <= last_next;
      dout_reg <= dout_next;
      dout_oe_reg <= dout_oe_next;
      strobe_reg <= strobe_next;
      taken_reg <= taken_next;
      rxv_reg <= rxv_next;
      rxw_reg <= rxw_next;
    end
  end

  // ********************************
  // Pin outputs
  // ********************************
  logic [LINES-1:0] pins_reg;
  logic [LINES-1:0] pins_oe_reg;
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      // R1 enable forces output, R2 same waveform
      always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pins_reg[g] <= 1'b0;
          pins_oe_reg[g] <= 1'b0;
        end else begin
          pins_reg[g] <= strobe_next;
          pins_oe_reg[g] <= output_next[PSG_ENABLE_LSB + g];
        end
      end
    end
  endgenerate
  assign strobe_pins_out = pins_reg;
  assign strobe_pins_oe_out = pins_oe_reg;
  assign data_pins_out = dout_reg;
  assign data_pins_oe_out = dout_oe_reg;
  assign tx_word_taken_out = taken_reg;
  assign rx_word_valid_out = rxv_reg;
  assign rx_word_out = rxw_reg;
  assign last_word_flag_out = last_reg;
endmodule

// ### verilog/psg_pkg.sv
// Package of constants and types for the parallel strobe generator
//
// Contract
// R1 - Each of eight control outputs has an enable bit; set means generator drives pin.
// R2 - One strobe generator; every enabled output carries the same waveform.
// R3 - From input pins: set idle level, load pin bits, set direction, then enables.
// R4 - From output pins: set idle level, load pin bits, then set enables.
// R5 - While running, exactly one strobe pulse per data word moved.
// R6 - Idle level bit zero of output control drives enabled outputs when idle.
// R7 - Prescaler bits 6:4 set cycle length to prescaler plus one base periods.
// R8 - Software never programs prescaler zero; one gives 30 MHz.
// R9 - Edge position bits 2:0 place the edge that many periods into cycle.
// R10 - Edge position must be above zero and not above prescaler, else no edge.
// R11 - Polarity bit 3: clear starts high and falls, set starts low and rises.
// R12 - Transmit drives each word at the start of its strobe cycle.
// R13 - Transmit starts toggling only once a transfer buffer holds data.
// R14 - Transmit underrun: idle cycles, release data pins, strobe at idle level.
// R15 - Receive, option set, buffers full: pause, idle level, release port.
// R16 - Receive, option clear, buffers full: hold level, sample word at stretch end.
// R17 - Software configures data pins as inputs for receive.
// R18 - Software programs idle level before other strobe parameters and enables.
// R19 - Writing one to start bit 15 launches transfer and clears last-word flag.
// R20 - Receive samples each word at cycle end or on strobe edge, as configured.
// R21 - Cycle counter restarts at each transfer start, aligned with first word.
package psg_pkg;
  localparam logic [11:0] PSG_TIMING_OFFSET = 12'h000;
  localparam logic [11:0] PSG_OUTPUT_OFFSET = 12'h004;
  localparam logic [11:0] PSG_STATUS_OFFSET = 12'h008;
  localparam logic [11:0] PSG_COUNT_OFFSET = 12'h00C;
  localparam int PSG_EDGE_LSB = 0;
  localparam int PSG_POL_BIT = 3;
  localparam int PSG_PRESC_LSB = 4;
  localparam int PSG_DIR_BIT = 7;
  localparam int PSG_OVR_BIT = 8;
  localparam int PSG_SAMPLE_EDGE_BIT = 9;
  localparam int PSG_STOP_BIT = 14;
  localparam int PSG_START_BIT = 15;
  localparam int PSG_IDLE_BIT = 0;
  localparam int PSG_ENABLE_LSB = 4;
  localparam logic [15:0] PSG_TIMING_RESET = 16'h0011;
  localparam logic [15:0] PSG_OUTPUT_RESET = 16'h0000;
  localparam int PSG_BASE_HZ = 60000000;
  localparam int PSG_SYS_HZ = 50000000;
  typedef enum logic [1:0] {
    PSG_IDLE = 2'b00,
    PSG_RUN = 2'b01,
    PSG_STALL = 2'b11
  } psg_state_type;
endpackage

// ### verilog/psg_cycle_timer.sv
// Base-period cycle timer producing the phase count and end-of-cycle mark
`timescale 1ns/1ns
module psg_cycle_timer (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic tick_in,
  input wire logic restart_in,
  input wire logic hold_in,
  input wire logic [2:0] presc_in,
  input wire logic [2:0] edge_in,
  output logic [2:0] phase_out,
  output logic cycle_end_out
);
  logic [2:0] phase_reg;
  logic [2:0] phase_next;
  always_comb begin
    phase_next = phase_reg;
    // R21 cycle counter restart
    if (restart_in) begin
      phase_next = 3'h0;
    end else if (tick_in && !hold_in) begin
      // R7 prescaler plus one
      phase_next = (phase_reg >= presc_in) ? 3'h0 : phase_reg + 3'h1;
    end
  end
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end
  assign phase_out = phase_reg;
  assign cycle_end_out = tick_in && !hold_in && !restart_in && (phase_reg >= presc_in);
endmodule

// ### sim/psg_sva.sv
// Port checker for the strobe generator
`timescale 1ns/1ns
module psg_sva #(
  parameter int DATA_WIDTH = 16,
  parameter int LINES = 8
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic tx_word_taken_out,
  input wire logic rx_word_valid_out,
  input wire logic [DATA_WIDTH-1:0] data_pins_out,
  input wire logic data_pins_oe_out,
  input wire logic [LINES-1:0] strobe_pins_out,
  input wire logic [LINES-1:0] strobe_pins_oe_out,
  input wire logic last_word_flag_out
);
  import psg_pkg::*;
  logic wr_out;
  logic wr_tim;
  logic off_idle;
  logic mixed;
  logic [LINES-1:0] en_reg;
  logic idle_reg;
  logic dir_reg;
  assign wr_out = psel_in && penable_in && pwrite_in && paddr_in == PSG_OUTPUT_OFFSET;
  assign wr_tim = psel_in && penable_in && pwrite_in && paddr_in == PSG_TIMING_OFFSET;
  assign off_idle = |((strobe_pins_out ^ {LINES{idle_reg}}) & strobe_pins_oe_out);
  assign mixed = |((strobe_pins_out ^ {LINES{|(strobe_pins_out & strobe_pins_oe_out)}})
    & strobe_pins_oe_out);
  // Shadow of the written fields, the checker cannot see the registers
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_reg <= '0;
      idle_reg <= 1'b0;
      dir_reg <= 1'b0;
    end else begin
      if (wr_out) begin
        en_reg <= pwdata_in[PSG_ENABLE_LSB +: LINES];
        idle_reg <= pwdata_in[PSG_IDLE_BIT];
      end
      if (wr_tim) begin
        dir_reg <= pwdata_in[PSG_DIR_BIT];
      end
    end
  end
  // ************************************
  // Properties
  // ************************************
  default clocking dcb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  enable_drive_a: assert property (wr_out |-> ##2 strobe_pins_oe_out == en_reg)
    else $error("enables not on outputs");
  same_wave_a: assert property ($stable(strobe_pins_oe_out)[*2] |-> !mixed)
    else $error("enabled lines differ");
  idle_level_a: assert property (last_word_flag_out[*3] ##0
    $stable(idle_reg) && $stable(strobe_pins_oe_out) |=> !off_idle) else $error("not idle");
  word_pulse_a: assert property (tx_word_taken_out |=> !tx_word_taken_out)
    else $error("taken pulse too long");
  rx_pulse_a: assert property (rx_word_valid_out |=> !rx_word_valid_out)
    else $error("receive pulse too long");
  word_hold_a: assert property (data_pins_oe_out && $past(data_pins_oe_out)
    && !tx_word_taken_out && !$past(tx_word_taken_out) |-> $stable(data_pins_out))
    else $error("data moved inside cycle");
  underrun_idle_a: assert property ((!dir_reg && !data_pins_oe_out)[*3] ##0
    $stable(idle_reg) && $stable(strobe_pins_oe_out) |=> !off_idle) else $error("stall");
  rx_release_a: assert property (dir_reg[*2] |-> !data_pins_oe_out)
    else $error("port driven in receive");
  start_clear_a: assert property (wr_tim && pwdata_in[PSG_START_BIT]
    |-> ##2 !last_word_flag_out) else $error("flag kept after start");
  tx_word_c: cover property (tx_word_taken_out);
  rx_word_c: cover property (rx_word_valid_out);
  done_c: cover property ($rose(last_word_flag_out));
endmodule
bind psg_top psg_sva #(.DATA_WIDTH(DATA_WIDTH), .LINES(LINES)) i_sva (.clk_sys_in,
  .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .tx_word_taken_out,
  .rx_word_valid_out, .data_pins_out, .data_pins_oe_out, .strobe_pins_out,
  .strobe_pins_oe_out, .last_word_flag_out);

// ### sim/psg_flash_model.sv
// Far-side parallel memory model
`timescale 1ns/1ns
module psg_flash_model (
  input wire logic clk_sys_in,
  input wire logic strobe_in,
  input wire logic pol_in,
  input wire logic drive_in,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out
);
  logic prev = 1'b0;
  logic [15:0] word = 16'hA500;
  int edges = 0;
  logic [15:0] cap [0:7];
  // Active edge leaves the cycle start level
  always @(posedge clk_sys_in) begin
    prev <= strobe_in;
    if (strobe_in !== prev && strobe_in === pol_in) begin
      cap[edges[2:0]] <= data_in;
      edges <= edges + 1;
      word <= word + 16'h0001;
    end
  end
  // drives only in receive
  // Released bus shows the complement so a stale value never matches
  assign data_out = drive_in ? word : ~word;
endmodule

// ### sim/psg_tb_top.sv
// Self-checking bench for the strobe generator
`timescale 1ns/1ns
module psg_tb_top;
  import psg_pkg::*;
  logic clk_sys_in = 1'b0;
  logic resetn_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0;
  logic tx_word_valid_in = 1'b0;
  logic [15:0] tx_word_in = 16'h0;
  logic rx_buffers_full_in = 1'b0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, tx_word_taken_out, rx_word_valid_out;
  logic [15:0] rx_word_out, data_pins_in, data_pins_out, got;
  logic data_pins_oe_out, last_word_flag_out;
  logic [7:0] strobe_pins_out, strobe_pins_oe_out;
  logic rx_mode = 1'b0;
  logic pol = 1'b0;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int num_checks = 0;
  int base, n;
  psg_top i_dut (.clk_sys_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .tx_word_valid_in, .tx_word_in,
    .tx_word_taken_out, .rx_buffers_full_in, .rx_word_valid_out, .rx_word_out,
    .data_pins_in, .data_pins_out, .data_pins_oe_out, .strobe_pins_out,
    .strobe_pins_oe_out, .last_word_flag_out);
  psg_flash_model i_flash (.clk_sys_in, .strobe_in(strobe_pins_out[1]), .pol_in(pol),
    .drive_in(rx_mode), .data_in(data_pins_out), .data_out(data_pins_in));
  initial begin
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  // ************************************
  // Bus and check tasks
  // ************************************
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_sys_in);
    penable_in <= 1'b1;
    do @(posedge clk_sys_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Bounded wait; sampling on the falling edge avoids races
  task automatic wait_hi(input int which, output int c);
    c = 0;
    do begin
      @(negedge clk_sys_in);
      c++;
      got = rx_word_out;
    end while (c < 300 && (which == 0 ? tx_word_taken_out : which == 1 ?
      rx_word_valid_out : last_word_flag_out) !== 1'b1);
    @(posedge clk_sys_in);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    failures++;
    summarize();
  end
  // ************************************
  // Tests
  // ************************************
  initial begin
    repeat (8) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    @(posedge clk_sys_in);
    apb(1'b0, PSG_TIMING_OFFSET, 32'h0);
    chk(rd, 32'(PSG_TIMING_RESET));
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, PSG_OUTPUT_OFFSET, 32'h1);
    apb(1'b1, PSG_COUNT_OFFSET, 32'h3);
    apb(1'b1, PSG_TIMING_OFFSET, 32'h22);
    apb(1'b1, PSG_OUTPUT_OFFSET, 32'hFF1);
    apb(1'b1, PSG_TIMING_OFFSET, 32'h8022);
    repeat (6) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk(strobe_pins_oe_out, 8'hFF);
    chk(strobe_pins_out, 8'hFF);
    chk(i_flash.edges, 0);
    tx_word_in <= 16'h1230;
    tx_word_valid_in <= 1'b1;
    wait_hi(0, n);
    tx_word_in <= 16'h1231;
    wait_hi(0, n);
    chk(n, 3);
    tx_word_valid_in <= 1'b0;
    tx_word_in <= 16'h1232;
    repeat (12) @(posedge clk_sys_in);
    chk(i_flash.edges, 2);
    tx_word_valid_in <= 1'b1;
    wait_hi(0, n);
    tx_word_valid_in <= 1'b0;
    wait_hi(2, n);
    for (int k = 0; k < 3; k++) chk(i_flash.cap[k], 16'h1230 + k);
    chk(i_flash.edges, 3);
    apb(1'b0, PSG_STATUS_OFFSET, 32'h0);
    chk(rd, 32'h4);
    pol <= 1'b1;
    rx_mode <= 1'b1;
    base = i_flash.edges;
    apb(1'b1, PSG_OUTPUT_OFFSET, 32'h0);
    apb(1'b1, PSG_COUNT_OFFSET, 32'h3);
    apb(1'b1, PSG_TIMING_OFFSET, 32'h1A9);
    apb(1'b1, PSG_OUTPUT_OFFSET, 32'h5A0);
    @(negedge clk_sys_in);
    chk(strobe_pins_oe_out, 8'h5A);
    chk(strobe_pins_out & 8'h5A, 8'h00);
    @(posedge clk_sys_in);
    apb(1'b1, PSG_TIMING_OFFSET, 32'h81A9);
    chk(last_word_flag_out, 1'b0);
    for (int k = 0; k < 3; k++) begin
      wait_hi(1, n);
      chk(got, 16'hA501 + base + k);
      if (k == 1) begin
        repeat (8) @(posedge clk_sys_in);
        chk(i_flash.edges, base + 2);
      end
      rx_buffers_full_in <= (k == 0);
    end
    wait_hi(2, n);
    chk(i_flash.edges, base + 3);
    summarize();
  end
endmodule
